// ---- hdl/stored_fault_diag_responder.sv ----
`timescale 1ns/1ps
module stored_fault_diag_responder #(
  parameter int MAX_FAULTS = 8,
  parameter int FIFO_DEPTH = 8,
  parameter int unsigned ACK_TIMEOUT_CYC = diag_pkg::ACK_TIMEOUT_CYC
) (
  input wire logic clk_sys_i,            // System clock, 200 MHz
  input wire logic reset_i,              // Async reset, active high
  input wire logic fault_valid_i,        // Fault event pulse
  input wire logic [18:0] fault_spn_i,   // Suspect parameter number
  input wire logic [4:0] fault_fmi_i,    // Failure mode
  input wire logic rx_valid_i,           // Received frame pulse
  input wire logic [28:0] rx_id_i,       // Received identifier
  input wire logic [3:0] rx_dlc_i,       // Received length
  input wire logic [63:0] rx_data_i,     // Received data, byte 0 low
  input wire logic tx_ready_i,           // Controller takes frame
  input wire logic [7:0] nvm_node_addr_i,// Node address held in NVM
  output logic tx_valid_o,               // Frame to send
  output logic [28:0] tx_id_o,           // Frame identifier
  output logic [3:0] tx_dlc_o,           // Frame length
  output logic [63:0] tx_data_o,         // Frame data, byte 0 low
  output logic nvm_save_o,               // Commit group to NVM, pulse
  output logic [7:0] nvm_group_o,        // Save group with the pulse
  output logic cfg_wr_o,                 // Volatile object write, pulse
  output logic [7:0] cfg_obj_o,          // Object index
  output logic [15:0] cfg_value_o,       // Object value
  output logic [7:0] node_addr_o,        // Node address in use
  output logic [7:0] node_addr_pend_o,   // Written, not yet applied
  output logic [7:0] fault_count_o,      // Stored fault entries
  output logic busy_o                    // Transfer session open
);
  localparam int FW = diag_pkg::FRAME_W;
  localparam int CW = $clog2(MAX_FAULTS + 1);

  typedef diag_pkg::entry_type [MAX_FAULTS-1:0] mem_type;

  typedef struct packed {
    diag_pkg::state_type st;
    logic [CW-1:0] cnt;
    mem_type mem;
    logic [7:0] nbytes;
    logic [7:0] npkts;
    logic [7:0] seq;
    logic [7:0] burst;
    logic [31:0] tmr;
    logic out_v;
    logic [FW-1:0] out_f;
    logic tx_v;
    logic [FW-1:0] tx_f;
    logic save_p;
    logic [7:0] grp;
    logic wr_p;
    logic [7:0] obj;
    logic [15:0] val;
    logic [7:0] node_pend;
    logic [7:0] node_act;
    logic started;
    logic busy;
  } regs_type;

  regs_type q;
  regs_type d;

  frame_stream_if #(.W(FW)) push_if();
  frame_stream_if #(.W(FW)) pop_if();

  frame_fifo #(
    .W(FW),
    .D(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .in_if(push_if),
    .out_if(pop_if)
  );

  assign push_if.valid = q.out_v;
  assign push_if.data = q.out_f;
  // Output register refills whenever it is empty or being taken
  assign pop_if.ready = !q.tx_v || tx_ready_i;

  function automatic logic [7:0] rx_byte(input logic [63:0] dat,
                                         input int i);
    return dat[8*i +: 8];
  endfunction

  // Payload byte idx of the report: header, codes, then padding
  function automatic logic [7:0] pay_byte(input mem_type m,
                                          input logic [7:0] idx,
                                          input logic [7:0] nb);
    logic [7:0] k;
    logic [7:0] r;
    k = 8'(idx - diag_pkg::HDR_BYTES);
    r = diag_pkg::PAD;
    if (idx >= nb) begin
      r = diag_pkg::PAD;
    end else if (idx < diag_pkg::HDR_BYTES) begin
      r = diag_pkg::ZERO;
    end else begin
      r = diag_pkg::code_byte(m[k[7:2]], k[1:0]);
    end
    return r;
  endfunction

  function automatic logic [63:0] dt_data(input mem_type m,
                                          input logic [7:0] s,
                                          input logic [7:0] nb);
    logic [63:0] r;
    logic [7:0] base;
    r = '0;
    base = 8'((s - 8'h01) * diag_pkg::PKT_BYTES);
    r[7:0] = s;
    for (int j = 0; j < 7; j++) begin
      r[8*j+8 +: 8] = pay_byte(m, 8'(base + 8'(j)), nb);
    end
    return r;
  endfunction

  logic [23:0] rx_pgn;
  logic [23:0] rx_grp;
  logic req_any;
  logic req_dm2;
  logic req_dm3;
  logic tpcm;
  logic cts;
  logic eom;
  logic wrq;

  assign rx_pgn = rx_data_i[23:0];
  assign rx_grp = rx_data_i[63:40];
  assign req_any = rx_valid_i && (rx_id_i == diag_pkg::REQ_ID) &&
                   (rx_dlc_i == diag_pkg::DLC_REQ);
  assign req_dm2 = req_any && (rx_pgn == diag_pkg::DM2_PGN);
  assign req_dm3 = req_any && (rx_pgn == diag_pkg::DM3_PGN);
  assign tpcm = rx_valid_i && (rx_id_i == diag_pkg::TPCM_RX_ID) &&
                (rx_grp == diag_pkg::DM2_PGN);
  assign cts = tpcm && (rx_byte(rx_data_i, 0) == diag_pkg::CB_CTS);
  assign eom = tpcm && (rx_byte(rx_data_i, 0) == diag_pkg::CB_EOM);
  assign wrq = rx_valid_i && (rx_id_i == diag_pkg::WR_REQ_ID) &&
               (rx_byte(rx_data_i, 0) == diag_pkg::CMD_WR);

  always_comb begin
    logic clr;
    logic hit;
    logic [7:0] nb;
    logic [7:0] b1;
    logic [7:0] b3;
    logic [7:0] b4;
    clr = 1'b0;
    hit = 1'b0;
    nb = 8'(diag_pkg::HDR_BYTES + 4 * q.cnt);
    b1 = rx_byte(rx_data_i, 1);
    b3 = rx_byte(rx_data_i, 3);
    b4 = rx_byte(rx_data_i, 4);
    d = q;
    d.save_p = 1'b0;
    d.wr_p = 1'b0;
    d.out_v = q.out_v && !push_if.ready;
    if (pop_if.ready) begin
      d.tx_v = pop_if.valid;
      d.tx_f = pop_if.data;
    end
    // Address stored in NVM is taken once, just after reset release
    if (!q.started) begin
      d.started = 1'b1;
      d.node_act = nvm_node_addr_i;
    end

    unique case (q.st)
      diag_pkg::ST_IDLE: begin
        // Requests are only decoded while the staging slot is free
        if (!q.out_v) begin
          if (req_dm2) begin
            d.out_v = 1'b1;
            if (q.cnt <= CW'(1)) begin
              d.out_f = diag_pkg::mk_frame(diag_pkg::DM2_ID,
                diag_pkg::DLC_FULL,
                {diag_pkg::PAD, diag_pkg::PAD,
                 diag_pkg::code_byte(q.mem[0], 2'h3) & {8{q.cnt[0]}},
                 diag_pkg::code_byte(q.mem[0], 2'h2) & {8{q.cnt[0]}},
                 diag_pkg::code_byte(q.mem[0], 2'h1) & {8{q.cnt[0]}},
                 diag_pkg::code_byte(q.mem[0], 2'h0) & {8{q.cnt[0]}},
                 diag_pkg::ZERO, diag_pkg::ZERO});
            end else begin
              d.nbytes = nb;
              d.npkts = 8'((nb + 8'd6) / diag_pkg::PKT_BYTES);
              d.out_f = diag_pkg::mk_frame(diag_pkg::TPCM_TX_ID,
                diag_pkg::DLC_FULL,
                {diag_pkg::DM2_PGN, diag_pkg::PAD, d.npkts,
                 diag_pkg::ZERO, nb, diag_pkg::CB_RTS});
              d.st = diag_pkg::ST_WAIT_CTS;
            end
          end else if (req_dm3) begin
            clr = 1'b1;
            d.out_v = 1'b1;
            d.out_f = diag_pkg::mk_frame(diag_pkg::ACKM_ID,
              diag_pkg::DLC_FULL,
              {diag_pkg::DM3_PGN, 40'h0000000000});
          end else if (wrq) begin
            d.out_v = 1'b1;
            d.out_f = diag_pkg::mk_frame(diag_pkg::WR_ACK_ID,
              diag_pkg::DLC_FULL,
              {diag_pkg::PAD, rx_data_i[55:8],
               diag_pkg::CMD_WR_OK});
            if (b1 == diag_pkg::OBJ_SAVE) begin
              d.save_p = 1'b1;
              d.grp = b3;
            end else begin
              d.wr_p = 1'b1;
              d.obj = b1;
              d.val = {b4, b3};
              if (b1 == diag_pkg::OBJ_NODE) begin
                d.node_pend = b3;
              end
            end
          end
        end
      end
      diag_pkg::ST_WAIT_CTS: begin
        // A zero packet count means hold; keep waiting
        if (cts && (b1 != diag_pkg::ZERO)) begin
          d.burst = b1;
          d.seq = (rx_byte(rx_data_i, 2) == diag_pkg::ZERO) ?
                  8'h01 : rx_byte(rx_data_i, 2);
          d.st = diag_pkg::ST_DT;
        end
      end
      diag_pkg::ST_DT: begin
        if (!q.out_v) begin
          d.out_v = 1'b1;
          d.out_f = diag_pkg::mk_frame(diag_pkg::TPDT_ID,
            diag_pkg::DLC_FULL,
            dt_data(q.mem, q.seq, q.nbytes));
          d.seq = 8'(q.seq + 8'h01);
          d.burst = 8'(q.burst - 8'h01);
          if (q.seq >= q.npkts) begin
            d.st = diag_pkg::ST_WAIT_ACK;
            d.tmr = '0;
          end else if (q.burst == 8'h01) begin
            d.st = diag_pkg::ST_WAIT_CTS;
          end
        end
      end
      diag_pkg::ST_WAIT_ACK: begin
        if (eom) begin
          d.st = diag_pkg::ST_IDLE;
        end else if (q.tmr >= 32'(ACK_TIMEOUT_CYC - 1)) begin
          if (!q.out_v) begin
            d.out_v = 1'b1;
            d.out_f = diag_pkg::mk_frame(diag_pkg::TPCM_TX_ID,
              diag_pkg::DLC_FULL,
              {diag_pkg::DM2_PGN, diag_pkg::PAD, diag_pkg::PAD,
               diag_pkg::PAD, diag_pkg::ABORT_TIMEOUT,
               diag_pkg::CB_ABORT});
            d.st = diag_pkg::ST_IDLE;
          end
        end else begin
          d.tmr = 32'(q.tmr + 32'h1);
        end
      end
    endcase

    // Registered so the session flag leaves the block from a flop
    d.busy = (d.st != diag_pkg::ST_IDLE);

    // Clear first, so a fault in the same cycle is kept
    if (clr) begin
      d.cnt = '0;
    end
    if (fault_valid_i) begin
      for (int i = 0; i < MAX_FAULTS; i++) begin
        if ((i < int'(d.cnt)) && !hit &&
            (d.mem[i].spn == fault_spn_i) &&
            (d.mem[i].fmi == fault_fmi_i)) begin
          hit = 1'b1;
          if (d.mem[i].oc != diag_pkg::OC_MAX) begin
            d.mem[i].oc = 7'(d.mem[i].oc + 7'h01);
          end
        end
      end
      // A full memory drops new codes but keeps counting known ones
      if (!hit && (int'(d.cnt) < MAX_FAULTS)) begin
        d.mem[d.cnt].spn = fault_spn_i;
        d.mem[d.cnt].fmi = fault_fmi_i;
        d.mem[d.cnt].oc = 7'h01;
        d.cnt = CW'(d.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
      q.st <= diag_pkg::ST_IDLE;
      q.node_pend <= diag_pkg::NODE_DEFAULT;
      q.node_act <= diag_pkg::NODE_DEFAULT;
    end else begin
      q <= d;
    end
  end

  assign tx_valid_o = q.tx_v;
  assign tx_id_o = q.tx_f[FW-1 -: diag_pkg::ID_W];
  assign tx_dlc_o = q.tx_f[67:64];
  assign tx_data_o = q.tx_f[63:0];
  assign nvm_save_o = q.save_p;
  assign nvm_group_o = q.grp;
  assign cfg_wr_o = q.wr_p;
  assign cfg_obj_o = q.obj;
  assign cfg_value_o = q.val;
  assign node_addr_o = q.node_act;
  assign node_addr_pend_o = q.node_pend;
  assign fault_count_o = 8'(q.cnt);
  assign busy_o = q.busy;
endmodule

// ---- common/diag_pkg.sv ----
// Functional notes
// - Every fault that occurs is recorded in the internal fault memory; the code drops new codes once MAX_FAULTS entries are held.
// - Stored-fault report is sent only as answer to a matching request.
// - One stored fault: single 8-byte frame, 00 00 code FF FF.
// - Code bytes: SPN low, SPN mid, SPN high+FMI, count capped at 127.
// - Several faults: request-to-send 0x10, byte count, packets, group number.
// - Data frames wait for clear-to-send 0x11 from the requester.
// - Data frames on 0x1CEBFF80: sequence number then seven payload bytes.
// - Payload is two zero bytes, codes back to back, 0xFF padding.
// - Payload filling the last frame exactly gets no padding, no extra frame.
// - Missing acknowledgement: abort frame FF, reason 03, group number.
// - Clear request CC FE 00 clears all stored faults.
// - After clearing, acknowledgement on 0x18E8FF80 with clear group number.
// - Object writes land in volatile storage only.
// - Write to object 5 commits the selected save group to NVM.
// - Accepted write is answered with a frame whose byte 0 is 0x06.
// - Saved node address is applied only after the next reset.
package diag_pkg;
  localparam int ID_W = 29;
  localparam int FRAME_W = ID_W + 4 + 64;
  localparam logic [28:0] REQ_ID = 29'h18EA80FF;
  localparam logic [28:0] DM2_ID = 29'h18FECB80;
  localparam logic [28:0] TPCM_TX_ID = 29'h1CECFF80;
  localparam logic [28:0] TPCM_RX_ID = 29'h1CEC80FF;
  localparam logic [28:0] TPDT_ID = 29'h1CEBFF80;
  localparam logic [28:0] ACKM_ID = 29'h18E8FF80;
  localparam logic [28:0] WR_REQ_ID = 29'h18EF8000;
  localparam logic [28:0] WR_ACK_ID = 29'h18EF0080;
  localparam logic [23:0] DM2_PGN = 24'h00FECB;
  localparam logic [23:0] DM3_PGN = 24'h00FECC;
  localparam logic [7:0] CB_RTS = 8'h10;
  localparam logic [7:0] CB_CTS = 8'h11;
  localparam logic [7:0] CB_EOM = 8'h13;
  localparam logic [7:0] CB_ABORT = 8'hFF;
  localparam logic [7:0] ABORT_TIMEOUT = 8'h03;
  localparam logic [7:0] CMD_WR = 8'h04;
  localparam logic [7:0] CMD_WR_OK = 8'h06;
  localparam logic [7:0] OBJ_SAVE = 8'h05;
  localparam logic [7:0] OBJ_NODE = 8'h1B;
  localparam logic [7:0] PAD = 8'hFF;
  localparam logic [7:0] ZERO = 8'h00;
  localparam logic [7:0] PKT_BYTES = 8'h07;
  localparam logic [7:0] HDR_BYTES = 8'h02;
  localparam logic [6:0] OC_MAX = 7'h7F;
  localparam logic [3:0] DLC_FULL = 4'h8;
  localparam logic [3:0] DLC_REQ = 4'h3;
  localparam logic [7:0] NODE_DEFAULT = 8'h80;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned ACK_TIMEOUT_MS = 1250;
  localparam int unsigned ACK_TIMEOUT_CYC = ACK_TIMEOUT_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_CTS,
    ST_DT,
    ST_WAIT_ACK
  } state_type;

  typedef struct packed {
    logic [18:0] spn;
    logic [4:0] fmi;
    logic [6:0] oc;
  } entry_type;

  function automatic logic [7:0] code_byte(input entry_type e,
                                           input logic [1:0] lane);
    logic [7:0] r;
    r = ZERO;
    unique case (lane)
      2'h0: r = e.spn[7:0];
      2'h1: r = e.spn[15:8];
      2'h2: r = {e.spn[18:16], e.fmi};
      2'h3: r = {1'b0, e.oc};
    endcase
    return r;
  endfunction

  function automatic logic [FRAME_W-1:0] mk_frame(input logic [28:0] id,
                                                  input logic [3:0] dlc,
                                                  input logic [63:0] data);
    return {id, dlc, data};
  endfunction
endpackage

// ---- common/frame_stream_if.sv ----
`timescale 1ns/1ps
interface frame_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// ---- hdl/frame_fifo.sv ----
`timescale 1ns/1ps
module frame_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk_sys_i,  // System clock
  input wire logic reset_i,    // Async reset, active high
  frame_stream_if.snk in_if,   // Fill side
  frame_stream_if.src out_if   // Drain side
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] n;
  } fifo_type;

  fifo_type q;
  fifo_type d;
  logic push;
  logic pop;

  assign in_if.ready = (q.n < (AW+1)'(D));
  assign out_if.valid = (q.n != '0);
  assign out_if.data = q.mem[q.rp];
  assign push = in_if.valid & in_if.ready;
  assign pop = out_if.valid & out_if.ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_if.data;
      d.wp = (q.wp == AW'(D - 1)) ? '0 : AW'(q.wp + 1'b1);
    end
    if (pop) begin
      d.rp = (q.rp == AW'(D - 1)) ? '0 : AW'(q.rp + 1'b1);
    end
    if (push && !pop) begin
      d.n = (AW+1)'(q.n + 1'b1);
    end else if (pop && !push) begin
      d.n = (AW+1)'(q.n - 1'b1);
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ---- verif/stored_fault_diag_responder_props.sv ----
`timescale 1ns/1ps
module stored_fault_diag_responder_props (
  input wire logic clk_sys_i, // Clock
  input wire logic reset_i, // Async reset
  input wire logic fault_valid_i, // Fault event
  input wire logic rx_valid_i, // Frame in
  input wire logic [28:0] rx_id_i, // Id in
  input wire logic [3:0] rx_dlc_i, // Length in
  input wire logic [63:0] rx_data_i, // Data in
  input wire logic tx_ready_i, // Frame taken
  input wire logic tx_valid_o, // Frame out
  input wire logic [28:0] tx_id_o, // Id out
  input wire logic [3:0] tx_dlc_o, // Length out
  input wire logic [63:0] tx_data_o, // Data out
  input wire logic nvm_save_o, // Save pulse
  input wire logic [7:0] nvm_group_o, // Save group
  input wire logic [7:0] node_addr_o, // Address in use
  input wire logic [7:0] fault_count_o, // Entries
  input wire logic busy_o // Session open
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  logic req_q;
  logic cts_q;
  logic [1:0] up_q;
  wire logic idle = !busy_o && !tx_valid_o;
  wire logic req_ok = rx_valid_i && rx_id_i == 29'h18EA80FF && rx_dlc_i == 4'h3;
  wire logic dm2_req = req_ok && rx_data_i[23:0] == 24'h00FECB;
  wire logic clr_req = req_ok && rx_data_i[23:0] == 24'h00FECC;
  wire logic save_wr = rx_valid_i && rx_id_i == 29'h18EF8000
                       && rx_data_i[15:0] == 16'h0504;
  wire logic dm2_out = tx_valid_o && tx_id_o == 29'h18FECB80;
  // Request memory lets an unsolicited report be caught
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      req_q <= 1'b0;
      cts_q <= 1'b0;
      up_q <= 2'h0;
    end else begin
      if (up_q != 2'h3) up_q <= up_q + 2'h1;
      if (dm2_req && !busy_o) req_q <= 1'b1;
      else if (dm2_out && tx_ready_i) req_q <= 1'b0;
      if (rx_valid_i && rx_id_i == 29'h1CEC80FF && rx_data_i[7:0] == 8'h11)
        cts_q <= 1'b1;
      else if (!busy_o) cts_q <= 1'b0;
    end
  end
  a_tx_hold_stable: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx frame changed while pending");
  a_report_solicited: assert property (dm2_out |-> req_q)
    else $error("stored-fault report without request");
  a_request_answered: assert property (
    dm2_req && idle |-> ##[3:12] tx_valid_o)
    else $error("request not answered");
  a_single_layout: assert property (dm2_out |-> tx_dlc_o == 4'h8
    && tx_data_o[15:0] == 16'h0000 && tx_data_o[63:48] == 16'hFFFF)
    else $error("single report layout wrong");
  a_count_top_bit: assert property (dm2_out |-> !tx_data_o[47])
    else $error("count byte bit 7 set");
  a_cm_group: assert property (
    tx_valid_o && tx_id_o == 29'h1CECFF80 |-> tx_data_o[63:40] == 24'h00FECB)
    else $error("control frame group number wrong");
  a_dt_after_cts: assert property (
    tx_valid_o && tx_id_o == 29'h1CEBFF80 |-> cts_q && busy_o)
    else $error("data frame before clear-to-send");
  a_clear_count: assert property (
    clr_req && idle && !fault_valid_i |=> fault_count_o == 8'h00)
    else $error("faults not cleared");
  a_clear_ack: assert property (clr_req && idle |-> ##[3:12]
    (tx_valid_o && tx_id_o == 29'h18E8FF80 && tx_data_o == 64'h00FECC0000000000))
    else $error("clear acknowledgement missing");
  a_first_fault: assert property (
    fault_valid_i && fault_count_o == 8'h00 && !rx_valid_i
    |=> fault_count_o == 8'h01)
    else $error("fault not recorded");
  a_save_group: assert property (
    save_wr && idle && rx_data_i[31:24] == 8'hA4
    |=> nvm_save_o && nvm_group_o == 8'hA4)
    else $error("save not committed");
  a_save_single: assert property (nvm_save_o |=> !nvm_save_o)
    else $error("save pulse too long");
  a_node_steady: assert property (up_q == 2'h3 |-> $stable(node_addr_o))
    else $error("node address changed without reset");
  c_single: cover property (dm2_out && tx_ready_i);
  c_abort: cover property (tx_valid_o && tx_data_o[15:0] == 16'h03FF);
  c_save: cover property (nvm_save_o);
endmodule

bind stored_fault_diag_responder stored_fault_diag_responder_props i_props (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .fault_valid_i(fault_valid_i),
  .rx_valid_i(rx_valid_i), .rx_id_i(rx_id_i), .rx_dlc_i(rx_dlc_i),
  .rx_data_i(rx_data_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
  .tx_id_o(tx_id_o), .tx_dlc_o(tx_dlc_o), .tx_data_o(tx_data_o),
  .nvm_save_o(nvm_save_o), .nvm_group_o(nvm_group_o),
  .node_addr_o(node_addr_o), .fault_count_o(fault_count_o), .busy_o(busy_o));

// ---- verif/diag_requester_model.sv ----
`timescale 1ns/1ps
module diag_requester_model (
  input wire logic clk_sys_i, // Clock
  input wire logic slow_i, // Stall every other cycle
  input wire logic tx_valid_i, // Device frame pending
  input wire logic [diag_pkg::FRAME_W-1:0] tx_frame_i, // Id, length, data
  output logic tx_ready_o // Frame taken
);
  logic [diag_pkg::FRAME_W-1:0] got_q[$];
  logic tog_q = 1'b0;
  // Every accepted frame is logged, so nothing unsolicited slips past
  always @(posedge clk_sys_i) begin
    tog_q <= ~tog_q;
    if (tx_valid_i && tx_ready_o) got_q.push_back(tx_frame_i);
  end
  assign tx_ready_o = !slow_i || tog_q;
endmodule

// ---- verif/tb_stored_fault_diag_responder.sv ----
`timescale 1ns/1ps
module tb_stored_fault_diag_responder;
  localparam int TMO = 50;
  localparam int FW = diag_pkg::FRAME_W;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic fault_valid_i = 1'b0;
  logic [18:0] fault_spn_i = 19'h0;
  logic [4:0] fault_fmi_i = 5'h0;
  logic rx_valid_i = 1'b0;
  logic [28:0] rx_id_i = 29'h0;
  logic [3:0] rx_dlc_i = 4'h0;
  logic [63:0] rx_data_i = 64'h0;
  logic [7:0] nvm_node_addr_i = 8'h5A;
  logic slow = 1'b0;
  logic tx_ready_i, tx_valid_o, nvm_save_o, cfg_wr_o, busy_o;
  logic [28:0] tx_id_o;
  logic [3:0] tx_dlc_o;
  logic [63:0] tx_data_o;
  logic [7:0] nvm_group_o, cfg_obj_o, node_addr_o, node_addr_pend_o;
  logic [7:0] fault_count_o;
  logic [15:0] cfg_value_o;
  logic [18:0] e_spn[8];
  logic [4:0] e_fmi[8];
  logic [6:0] e_oc[8];
  int n_e = 0;
  int num_errors = 0;
  int cmp_count = 0;

  initial forever #2.5 clk_sys_i = ~clk_sys_i;

  // Short ack timeout keeps the abort case quick
  stored_fault_diag_responder #(.ACK_TIMEOUT_CYC(TMO)) i_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .fault_valid_i(fault_valid_i),
    .fault_spn_i(fault_spn_i), .fault_fmi_i(fault_fmi_i),
    .rx_valid_i(rx_valid_i), .rx_id_i(rx_id_i), .rx_dlc_i(rx_dlc_i),
    .rx_data_i(rx_data_i), .tx_ready_i(tx_ready_i),
    .nvm_node_addr_i(nvm_node_addr_i), .tx_valid_o(tx_valid_o),
    .tx_id_o(tx_id_o), .tx_dlc_o(tx_dlc_o), .tx_data_o(tx_data_o),
    .nvm_save_o(nvm_save_o), .nvm_group_o(nvm_group_o), .cfg_wr_o(cfg_wr_o),
    .cfg_obj_o(cfg_obj_o), .cfg_value_o(cfg_value_o),
    .node_addr_o(node_addr_o), .node_addr_pend_o(node_addr_pend_o),
    .fault_count_o(fault_count_o), .busy_o(busy_o));

  diag_requester_model i_model (
    .clk_sys_i(clk_sys_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
    .tx_frame_i({tx_id_o, tx_dlc_o, tx_data_o}), .tx_ready_o(tx_ready_i));

  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [FW-1:0] got, input logic [FW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Payload byte i: two zero bytes, codes back to back, then padding
  function automatic logic [7:0] pb(input int i);
    int j;
    j = i - 2;
    if (i < 2) return 8'h00;
    if (j >= 4 * n_e) return 8'hFF;
    case (j % 4)
      0: return e_spn[j / 4][7:0];
      1: return e_spn[j / 4][15:8];
      2: return {e_spn[j / 4][18:16], e_fmi[j / 4]};
      default: return {1'b0, e_oc[j / 4]};
    endcase
  endfunction

  function automatic logic [63:0] row(input int base);
    logic [63:0] r;
    for (int b = 0; b < 8; b++) r[8 * b +: 8] = pb(base + b);
    return r;
  endfunction

  task automatic send_rx(input logic [28:0] id, input logic [3:0] dlc,
                         input logic [63:0] d);
    @(posedge clk_sys_i);
    rx_valid_i <= 1'b1;
    rx_id_i <= id;
    rx_dlc_i <= dlc;
    rx_data_i <= d;
    @(posedge clk_sys_i);
    rx_valid_i <= 1'b0;
  endtask

  task automatic fault(input logic [18:0] s, input logic [4:0] f);
    int k;
    for (k = 0; k < n_e && !(e_spn[k] == s && e_fmi[k] == f); k++);
    if (k == n_e) begin
      e_spn[k] = s;
      e_fmi[k] = f;
      e_oc[k] = 7'h00;
      n_e++;
    end
    if (e_oc[k] != 7'h7F) e_oc[k]++;
    @(posedge clk_sys_i);
    fault_valid_i <= 1'b1;
    fault_spn_i <= s;
    fault_fmi_i <= f;
    @(posedge clk_sys_i);
    fault_valid_i <= 1'b0;
  endtask

  task automatic take(input logic [28:0] id, input logic [63:0] d);
    int k;
    for (k = 0; k < 400 && i_model.got_q.size() == 0; k++)
      @(posedge clk_sys_i);
    if (i_model.got_q.size() == 0) begin
      num_errors++;
      $display("MISMATCH t=%0t no frame", $time);
      conclude();
    end else chk(i_model.got_q.pop_front(), {id, 4'h8, d});
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge clk_sys_i);
    chk(i_model.got_q.size(), 0);
  endtask

  task automatic run_multi(input bit eom);
    int nb;
    int np;
    logic [63:0] d;
    nb = 2 + 4 * n_e;
    np = (nb + 6) / 7;
    send_rx(29'h18EA80FF, 4'h3, 64'hFECB);
    take(29'h1CECFF80, {24'h00FECB, 8'hFF, np[7:0], nb[15:0], 8'h10});
    quiet(20);
    send_rx(29'h1CEC80FF, 4'h8, {40'h00FECBFFFF, 8'h01, np[7:0], 8'h11});
    for (int p = 0; p < np; p++) begin
      d = row(7 * p - 1);
      d[7:0] = p[7:0] + 8'h01;
      take(29'h1CEBFF80, d);
    end
    if (eom) begin
      send_rx(29'h1CEC80FF, 4'h8, {32'h00FECBFF, np[7:0], nb[15:0], 8'h13});
      quiet(TMO + 20);
      chk(busy_o, 1'b0);
    end else take(29'h1CECFF80, 64'h00FECBFFFFFF03FF);
  endtask

  task automatic t_single();
    repeat (130) fault(19'h7F260, 5'h04);
    quiet(5);
    chk(fault_count_o, 8'h01);
    send_rx(29'h18EA80FF, 4'h4, 64'hFECB);
    quiet(12);
    send_rx(29'h18EA80FF, 4'h3, 64'hFECB);
    take(29'h18FECB80, row(0));
  endtask

  task automatic t_clear();
    send_rx(29'h18EA80FF, 4'h3, 64'hFECC);
    #1;
    chk(fault_count_o, 8'h00);
    n_e = 0;
    take(29'h18E8FF80, 64'h00FECC0000000000);
  endtask

  task automatic t_multi();
    slow = 1'b1;
    fault(19'h7F250, 5'h03);
    repeat (2) fault(19'h7F072, 5'h02);
    repeat (2) fault(19'h7F070, 5'h02);
    run_multi(1'b1);
    fault(19'h7F074, 5'h02);
    run_multi(1'b0);
    slow = 1'b0;
  endtask

  task automatic t_write();
    send_rx(29'h18EF8000, 4'h8, 64'hFF00000085001B04);
    #1;
    chk({cfg_wr_o, cfg_obj_o, cfg_value_o}, 25'h11B0085);
    chk({node_addr_pend_o, node_addr_o}, 16'h855A);
    take(29'h18EF0080, 64'hFF00000085001B06);
    send_rx(29'h18EF8000, 4'h8, 64'h00000000A4000504);
    #1;
    chk({nvm_save_o, nvm_group_o}, 9'h1A4);
    take(29'h18EF0080, 64'hFF000000A4000506);
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    nvm_node_addr_i <= 8'h85;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk({node_addr_pend_o, node_addr_o}, 16'h8085);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk({node_addr_o, fault_count_o}, 16'h5A00);
    t_single();
    t_clear();
    t_multi();
    t_write();
    conclude();
  end
endmodule
